//--- inc/lbp_pkg.sv
// Package for the lock bit protection decoder: register map, fields, types
package lbp_pkg;

	// APB register byte addresses
	localparam logic [7:0] ADDR_LOCK     = 8'h00;
	localparam logic [7:0] ADDR_EFUSE    = 8'h04;
	localparam logic [7:0] ADDR_PROG_CMD = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_BOUNDARY = 8'h10;
	localparam logic [7:0] ADDR_ERASE    = 8'h14;

	// Lock byte field positions
	localparam int MEM_LOCK_LO_BIT  = 0;
	localparam int MEM_LOCK_HI_BIT  = 1;
	localparam int APP_LOCK_LO_BIT  = 2;
	localparam int APP_LOCK_HI_BIT  = 3;
	localparam int BOOT_LOCK_LO_BIT = 4;
	localparam int BOOT_LOCK_HI_BIT = 5;

	// Unused lock bits read as one, written bits may only clear
	localparam logic [7:0] LOCK_RESET   = 8'hFF;
	localparam logic [7:0] LOCK_UNUSED  = 8'hC0;
	localparam logic [7:0] BOOT_LOCK_MSK = 8'h30;

	// Extended fuse byte
	localparam logic [7:0] EFUSE_RESET  = 8'hFF;
	localparam logic [7:0] EFUSE_UNUSED = 8'hF0;
	localparam logic [7:0] EFUSE_BOD_MSK = 8'h0E;
	localparam int BOD_LVL_LSB = 1;
	localparam int BOD_LVL_MSB = 3;

	// Chip erase key and status bit positions
	localparam logic [31:0] ERASE_KEY = 32'h0000_C5E1;
	localparam int ST_REFUSED_BIT = 0;
	localparam int ST_SPM_REJ_BIT = 1;
	localparam int ST_LPM_REJ_BIT = 2;
	localparam int ST_IRQ_MSK_BIT = 3;

	// Program memory word address width and default boot start
	localparam int PADDR_W = 13;
	localparam logic [12:0] BOOT_START_RST = 13'h1C00;

	// Programmer command codes in the command register low bits
	typedef enum logic [1:0] {
		PCMD_NONE    = 2'b00,
		PCMD_PROGMEM = 2'b01,
		PCMD_VERIFY  = 2'b10,
		PCMD_FUSE    = 2'b11
	} lbp_pcmd_e;

	// Two-bit lock field modes, decoded from (hi, lo)
	typedef enum logic [1:0] {
		LMODE_1 = 2'b11,
		LMODE_2 = 2'b10,
		LMODE_3 = 2'b00,
		LMODE_4 = 2'b01
	} lbp_lmode_e;

	// CPU program-memory request
	typedef struct packed {
		logic               valid;
		logic               isStore;
		logic [12:0]        addr;
		logic               execInBoot;
		logic               vecInBoot;
	} lbp_cpu_req_s;

	// CPU grant answer
	typedef struct packed {
		logic spmAllow;
		logic lpmAllow;
		logic irqMask;
	} lbp_cpu_ans_s;

endpackage

//--- hdl/lbp_lock_decoder.sv
// Lock and fuse bit protection decoder with APB register access
`timescale 1ns/100ps

module lbp_lock_decoder (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// CPU program-memory request and answer
	input  wire lbp_pkg::lbp_cpu_req_s cpuReq,
	output lbp_pkg::lbp_cpu_ans_s      cpuAns,
	// Programmer permissions
	output logic                      progWriteOk,
	output logic                      progVerifyOk,
	output logic                      fuseWriteOk,
	// Decoded fuse fields
	output logic [2:0]                brownoutLevel
);

	logic [7:0]  lockByte_q;
	logic [7:0]  efuse_q;
	logic [7:0]  fuseHigh_q;
	logic [7:0]  fuseLow_q;
	logic [12:0] bootStart_q;
	logic [3:0]  status_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	lbp_pkg::lbp_cpu_ans_s cpuAns_q;
	logic        progWriteOk_q;
	logic        progVerifyOk_q;
	logic        fuseWriteOk_q;
	logic [2:0]  bodLevel_q;

	lbp_pkg::lbp_lmode_e memMode;
	lbp_pkg::lbp_lmode_e appMode;
	lbp_pkg::lbp_lmode_e bootMode;

	logic        setup;
	logic        wrEn;
	logic        rdEn;
	logic        addrOk;
	logic        memFuseFrozen;
	logic        bootLockFrozen;
	lbp_pkg::lbp_pcmd_e progCmd;
	logic        progRefused;
	logic        targetBoot;
	logic        spmOk;
	logic        lpmOk;
	logic        irqMsk;

	// Shared decode of a two-bit lock field into its mode
	function automatic lbp_pkg::lbp_lmode_e lockMode(input logic hi,
	                                                 input logic lo);
		lockMode = lbp_pkg::lbp_lmode_e'({hi, lo});
	endfunction

	// Store blocked in modes 2 and 3
	function automatic logic storeBlocked(input lbp_pkg::lbp_lmode_e m);
		storeBlocked = (m == lbp_pkg::LMODE_2) || (m == lbp_pkg::LMODE_3);
	endfunction

	// Cross-section load blocked and vectors masked in modes 3 and 4
	function automatic logic crossBlocked(input lbp_pkg::lbp_lmode_e m);
		crossBlocked = (m == lbp_pkg::LMODE_3) || (m == lbp_pkg::LMODE_4);
	endfunction

	// Decode always from stored lock bits
	assign memMode  = lockMode(lockByte_q[lbp_pkg::MEM_LOCK_HI_BIT],
	                           lockByte_q[lbp_pkg::MEM_LOCK_LO_BIT]);
	assign appMode  = lockMode(lockByte_q[lbp_pkg::APP_LOCK_HI_BIT],
	                           lockByte_q[lbp_pkg::APP_LOCK_LO_BIT]);
	assign bootMode = lockMode(lockByte_q[lbp_pkg::BOOT_LOCK_HI_BIT],
	                           lockByte_q[lbp_pkg::BOOT_LOCK_LO_BIT]);

	assign setup  = psel && !penable;
	assign wrEn   = psel && penable && pwrite && pready_q;
	assign rdEn   = setup && !pwrite;
	assign addrOk = (paddr == lbp_pkg::ADDR_LOCK) ||
	                (paddr == lbp_pkg::ADDR_EFUSE) ||
	                (paddr == lbp_pkg::ADDR_PROG_CMD) ||
	                (paddr == lbp_pkg::ADDR_STATUS) ||
	                (paddr == lbp_pkg::ADDR_BOUNDARY) ||
	                (paddr == lbp_pkg::ADDR_ERASE);

	// Memory lock gating of the programmer
	always_comb begin
		memFuseFrozen  = 1'b0;
		bootLockFrozen = 1'b0;
		unique case (memMode)
			lbp_pkg::LMODE_1: begin
				memFuseFrozen = 1'b0;
			end
			lbp_pkg::LMODE_2: begin
				memFuseFrozen = 1'b1;
			end
			lbp_pkg::LMODE_3: begin
				memFuseFrozen  = 1'b1;
				bootLockFrozen = 1'b1;
			end
			lbp_pkg::LMODE_4: begin
				// Unlisted pairing treated as mode 2, the safer reading
				memFuseFrozen = 1'b1;
			end
		endcase
	end

	assign progCmd = lbp_pkg::lbp_pcmd_e'(pwdata[1:0]);
	always_comb begin
		progRefused = 1'b0;
		unique case (progCmd)
			lbp_pkg::PCMD_NONE:    progRefused = 1'b0;
			lbp_pkg::PCMD_PROGMEM: progRefused = memFuseFrozen;
			lbp_pkg::PCMD_VERIFY:  progRefused = memMode == lbp_pkg::LMODE_3;
			lbp_pkg::PCMD_FUSE:    progRefused = memFuseFrozen;
		endcase
	end

	// Section decode for CPU stores and loads
	assign targetBoot = cpuReq.addr >= bootStart_q;
	always_comb begin
		spmOk = 1'b1;
		lpmOk = 1'b1;
		if (targetBoot) begin
			spmOk = !storeBlocked(bootMode);
			lpmOk = cpuReq.execInBoot || !crossBlocked(bootMode);
		end else begin
			spmOk = !storeBlocked(appMode);
			lpmOk = !cpuReq.execInBoot || !crossBlocked(appMode);
		end
	end

	// Interrupt masking depends on vector placement and running section
	always_comb begin
		irqMsk = 1'b0;
		if (cpuReq.vecInBoot && !cpuReq.execInBoot)
			irqMsk = crossBlocked(appMode);
		else if (!cpuReq.vecInBoot && cpuReq.execInBoot)
			irqMsk = crossBlocked(bootMode);
	end

	// Lock byte: writes only program bits, erase alone restores ones
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lockByte_q <= lbp_pkg::LOCK_RESET;
		end else if (wrEn && paddr == lbp_pkg::ADDR_ERASE &&
		             pwdata == lbp_pkg::ERASE_KEY) begin
			lockByte_q <= lbp_pkg::LOCK_RESET;
		end else if (wrEn && paddr == lbp_pkg::ADDR_LOCK) begin
			// Boot-lock bits frozen in memory mode 3
			lockByte_q <= (lockByte_q & (pwdata[7:0] |
			               (bootLockFrozen ? lbp_pkg::BOOT_LOCK_MSK : 8'h00)))
			              | lbp_pkg::LOCK_UNUSED;
		end
	end

	// Fuse bytes; contents survive chip erase
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			efuse_q    <= lbp_pkg::EFUSE_RESET;
			fuseHigh_q <= lbp_pkg::EFUSE_RESET;
			fuseLow_q  <= lbp_pkg::EFUSE_RESET;
		end else if (wrEn && paddr == lbp_pkg::ADDR_EFUSE && !memFuseFrozen) begin
			efuse_q    <= pwdata[7:0] | lbp_pkg::EFUSE_UNUSED;
			fuseHigh_q <= pwdata[15:8];
			fuseLow_q  <= pwdata[23:16];
		end
	end

	// Boundary between application and boot sections
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			bootStart_q <= lbp_pkg::BOOT_START_RST;
		else if (wrEn && paddr == lbp_pkg::ADDR_BOUNDARY)
			bootStart_q <= pwdata[lbp_pkg::PADDR_W-1:0];
	end

	// Sticky status bits 0 to 2: hardware set wins over write-one-to-clear; bit 3 follows irqMsk
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			status_q <= 4'h0;
		end else begin
			for (int i = 0; i <= lbp_pkg::ST_LPM_REJ_BIT; i++) begin
				if (wrEn && paddr == lbp_pkg::ADDR_STATUS && pwdata[i])
					status_q[i] <= 1'b0;
			end
			if (wrEn && paddr == lbp_pkg::ADDR_PROG_CMD && progRefused)
				status_q[lbp_pkg::ST_REFUSED_BIT] <= 1'b1;
			if (cpuReq.valid && cpuReq.isStore && !spmOk)
				status_q[lbp_pkg::ST_SPM_REJ_BIT] <= 1'b1;
			if (cpuReq.valid && !cpuReq.isStore && !lpmOk)
				status_q[lbp_pkg::ST_LPM_REJ_BIT] <= 1'b1;
			status_q[lbp_pkg::ST_IRQ_MSK_BIT] <= irqMsk;
		end
	end

	// APB answer: no wait state, read data captured in setup
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !addrOk;
			if (rdEn) begin
				unique case (paddr)
					lbp_pkg::ADDR_LOCK:
						prdata_q <= {24'h00_0000, lockByte_q};
					lbp_pkg::ADDR_EFUSE:
						prdata_q <= {8'h00, fuseLow_q, fuseHigh_q, efuse_q};
					lbp_pkg::ADDR_STATUS:
						prdata_q <= {28'h000_0000, status_q};
					lbp_pkg::ADDR_BOUNDARY:
						prdata_q <= {19'h0_0000, bootStart_q};
					default:
						prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Registered permissions to CPU and programmer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cpuAns_q       <= '0;
			progWriteOk_q  <= 1'b0;
			progVerifyOk_q <= 1'b0;
			fuseWriteOk_q  <= 1'b0;
			bodLevel_q     <= lbp_pkg::EFUSE_RESET[lbp_pkg::BOD_LVL_MSB:
			                                       lbp_pkg::BOD_LVL_LSB];
		end else begin
			cpuAns_q.spmAllow <= cpuReq.valid && cpuReq.isStore && spmOk;
			cpuAns_q.lpmAllow <= cpuReq.valid && !cpuReq.isStore && lpmOk;
			cpuAns_q.irqMask  <= irqMsk;
			progWriteOk_q  <= !memFuseFrozen;
			progVerifyOk_q <= memMode != lbp_pkg::LMODE_3;
			fuseWriteOk_q  <= !memFuseFrozen;
			bodLevel_q <= efuse_q[lbp_pkg::BOD_LVL_MSB:lbp_pkg::BOD_LVL_LSB];
		end
	end

	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign prdata        = prdata_q;
	assign cpuAns        = cpuAns_q;
	assign progWriteOk   = progWriteOk_q;
	assign progVerifyOk  = progVerifyOk_q;
	assign fuseWriteOk   = fuseWriteOk_q;
	assign brownoutLevel = bodLevel_q;

endmodule // lbp_lock_decoder

//--- testbench/lbp_lock_decoder_props.sv
// Port checker for the lock decoder
`timescale 1ns/100ps
module lbp_lock_decoder_props (
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	// APB
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// CPU side
	input wire lbp_pkg::lbp_cpu_req_s cpuReq,
	input wire lbp_pkg::lbp_cpu_ans_s cpuAns,
	// Programmer side
	input wire logic                  progWriteOk,
	input wire logic                  progVerifyOk,
	input wire logic                  fuseWriteOk,
	input wire logic [2:0]            brownoutLevel
);
	logic wrDone;
	logic wrErase;
	logic wrEfuse;

	assign wrDone  = psel && penable && pwrite && pready;
	assign wrErase = wrDone && paddr == lbp_pkg::ADDR_ERASE;
	assign wrEfuse = wrDone && paddr == lbp_pkg::ADDR_EFUSE;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_apb_ready:
	assert property (psel && !penable |=> pready)
		else $error("No pready after setup");
	a_unmapped_err:
	assert property (pready |-> pslverr == (paddr[1:0] != 2'b00
		|| paddr > lbp_pkg::ADDR_ERASE) && (!pslverr || prdata == 32'h0))
		else $error("Error response wrong");
	a_store_cause:
	assert property (cpuAns.spmAllow |-> $past(cpuReq.valid && cpuReq.isStore))
		else $error("Store grant without store");
	a_load_cause:
	assert property (cpuAns.lpmAllow |-> $past(cpuReq.valid && !cpuReq.isStore))
		else $error("Load grant without load");
	a_irq_cause:
	assert property (cpuAns.irqMask
		|-> $past(cpuReq.vecInBoot != cpuReq.execInBoot))
		else $error("Interrupt mask without section split");
	a_fuse_lock:
	assert property (fuseWriteOk == progWriteOk)
		else $error("Fuse and program permission differ");
	a_verify_order:
	assert property (progWriteOk |-> progVerifyOk)
		else $error("Write allowed while verify refused");
	a_lock_restore:
	assert property ($rose(progWriteOk) && $past(rst_n, 3)
		|-> $past(wrErase) || $past(wrErase, 2))
		else $error("Lock released without erase");
	a_bod_change:
	assert property ($changed(brownoutLevel) |-> $past(wrEfuse)
		|| $past(wrEfuse, 2))
		else $error("Brown-out level moved without fuse write");

	c_store_ok: cover property (cpuAns.spmAllow);
	c_slv_err: cover property (pready && pslverr);
	c_irq_mask: cover property (cpuAns.irqMask);
	c_lock_free: cover property ($rose(progWriteOk));
endmodule // lbp_lock_decoder_props

bind lbp_lock_decoder lbp_lock_decoder_props i_props (.sys_clk, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
	.cpuReq, .cpuAns, .progWriteOk, .progVerifyOk, .fuseWriteOk,
	.brownoutLevel);

//--- testbench/lbp_cpu_model.sv
// CPU core model issuing store and load requests
`timescale 1ns/100ps
module lbp_cpu_model (
	// Clock
	input wire logic                  sys_clk,
	// Request and answer
	output lbp_pkg::lbp_cpu_req_s     cpuReq,
	input wire lbp_pkg::lbp_cpu_ans_s cpuAns
);
	initial cpuReq = '0;

	task automatic access(input logic st, input logic [12:0] ad,
		input logic eib, vib, output lbp_pkg::lbp_cpu_ans_s ans);
		@(posedge sys_clk);
		cpuReq <= {1'b1, st, ad, eib, vib};
		// Answer to the request stands in the cycle after it is taken
		repeat (2) @(posedge sys_clk);
		ans = cpuAns;
		// Idle fields flipped so a stale address is never trusted
		cpuReq <= {2'b00, ~ad, ~eib, ~vib};
	endtask
endmodule // lbp_cpu_model

//--- testbench/tb_lbp_lock_decoder.sv
// Testbench for the lock decoder
`timescale 1ns/100ps
module tb_lbp_lock_decoder;
	logic                  sys_clk = 1'b0;
	logic                  rst_n, psel, penable, pwrite, err;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rdat, lk;
	logic                  pready, pslverr;
	logic                  progWriteOk, progVerifyOk, fuseWriteOk;
	logic [2:0]            brownoutLevel;
	logic [1:0]            am, bm;
	lbp_pkg::lbp_cpu_req_s cpuReq;
	lbp_pkg::lbp_cpu_ans_s cpuAns;
	int                    n_mismatch, n_tests;
	logic [1:0]            codes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
	localparam logic [12:0] BT = lbp_pkg::BOOT_START_RST;

	always #2 sys_clk = ~sys_clk;

	lbp_lock_decoder i_lbp_lock_decoder (.sys_clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .cpuReq,
		.cpuAns, .progWriteOk, .progVerifyOk, .fuseWriteOk, .brownoutLevel);
	lbp_cpu_model i_lbp_cpu_model (.sys_clk, .cpuReq, .cpuAns);

	task automatic close_out();
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		// Answer taken at the edge where pready is sampled high
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), e, rdat);
	endtask

	task automatic op(input logic st, input logic [12:0] ad,
		input logic eib, vib, input logic [2:0] e);
		lbp_pkg::lbp_cpu_ans_s a;
		i_lbp_cpu_model.access(st, ad, eib, vib, a);
		chk($sformatf("cpuAns %b %h", st, ad), 32'(e), 32'(a));
	endtask

	task automatic perm(input logic [2:0] e);
		chk("progOk", 32'(e), 32'({progWriteOk, progVerifyOk, fuseWriteOk}));
	endtask

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(lbp_pkg::ADDR_LOCK, 32'h0000_00FF);
		rdc(lbp_pkg::ADDR_EFUSE, 32'h00FF_FFFF);
		chk("bodLevel", 32'h7, 32'(brownoutLevel));
		perm(3'b111);
		rdc(8'h18, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		// Fuses first, while memory lock still open
		xfer(1'b1, lbp_pkg::ADDR_EFUSE, 32'h00A5_5A03);
		rdc(lbp_pkg::ADDR_EFUSE, 32'h00A5_5AF3);
		chk("bodLevel", 32'h1, 32'(brownoutLevel));
		$display("Done: reset and fuses");
		// Boot mode offset from app mode so the fields cannot be swapped
		for (int i = 0; i < 4; i++) begin
			am = codes[i];
			bm = codes[(i + 1) % 4];
			lk = {24'h0, 2'b11, bm, am, 2'b11};
			xfer(1'b1, lbp_pkg::ADDR_ERASE, lbp_pkg::ERASE_KEY);
			xfer(1'b1, lbp_pkg::ADDR_LOCK, lk);
			op(1, 0, 0, 0, {am[0], 2'b00});
			op(1, BT, 1, 1, {bm[0], 2'b00});
			op(0, 0, 1, 1, {1'b0, am[1], 1'b0});
			op(0, BT, 0, 0, {1'b0, bm[1], 1'b0});
			op(0, 0, 0, 1, {2'b01, ~am[1]});
			op(0, BT, 1, 0, {2'b01, ~bm[1]});
			rdc(lbp_pkg::ADDR_LOCK, lk);
			$display("Done: section modes %b %b", am, bm);
		end
		xfer(1'b1, lbp_pkg::ADDR_ERASE, lbp_pkg::ERASE_KEY);
		xfer(1'b1, lbp_pkg::ADDR_LOCK, 32'h0000_00FE);
		rdc(lbp_pkg::ADDR_LOCK, 32'h0000_00FE);
		perm(3'b010);
		xfer(1'b1, lbp_pkg::ADDR_EFUSE, 32'h0);
		rdc(lbp_pkg::ADDR_EFUSE, 32'h00A5_5AF3);
		xfer(1'b1, lbp_pkg::ADDR_PROG_CMD, 32'h1);
		// Store and load rejections left over from the section loop
		rdc(lbp_pkg::ADDR_STATUS, 32'h7);
		xfer(1'b1, lbp_pkg::ADDR_STATUS, 32'h7);
		xfer(1'b1, lbp_pkg::ADDR_PROG_CMD, 32'h2);
		rdc(lbp_pkg::ADDR_STATUS, 32'h0);
		xfer(1'b1, lbp_pkg::ADDR_LOCK, 32'h0000_00FF);
		xfer(1'b1, lbp_pkg::ADDR_ERASE, 32'h0000_1234);
		rdc(lbp_pkg::ADDR_LOCK, 32'h0000_00FE);
		xfer(1'b1, lbp_pkg::ADDR_LOCK, 32'h0000_00FC);
		xfer(1'b1, lbp_pkg::ADDR_LOCK, 32'h0000_0000);
		rdc(lbp_pkg::ADDR_LOCK, 32'h0000_00F0);
		perm(3'b000);
		// Application pair now 00, idle CPU has vectors in boot: mask live
		xfer(1'b1, lbp_pkg::ADDR_PROG_CMD, 32'h2);
		rdc(lbp_pkg::ADDR_STATUS, 32'h9);
		xfer(1'b1, lbp_pkg::ADDR_ERASE, lbp_pkg::ERASE_KEY);
		rdc(lbp_pkg::ADDR_LOCK, 32'h0000_00FF);
		perm(3'b111);
		// Moved boundary must steer the section decode
		xfer(1'b1, lbp_pkg::ADDR_BOUNDARY, 32'h0000_1000);
		rdc(lbp_pkg::ADDR_BOUNDARY, 32'h0000_1000);
		xfer(1'b1, lbp_pkg::ADDR_LOCK, 32'h0000_00EF);
		op(1, 13'h1000, 0, 0, 3'b000);
		op(1, 13'h0FFF, 0, 0, 3'b100);
		rdc(lbp_pkg::ADDR_STATUS, 32'h3);
		xfer(1'b1, lbp_pkg::ADDR_STATUS, 32'h3);
		rdc(lbp_pkg::ADDR_STATUS, 32'h0);
		$display("Done: memory lock modes");
		close_out();
	end
endmodule // tb_lbp_lock_decoder
